// file: irq_arb_pkg.sv
// Constants, state types and carriers of the interrupt arbiter
`default_nettype none
package irq_arb_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_TPAIR = 8'h00;
    localparam logic [7:0] OFS_MISC = 8'h04;
    localparam logic [7:0] OFS_ICTL = 8'h08;
    localparam logic [7:0] OFS_EDGE = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] TPAIR_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [10:0] ICTL_RST = 11'h000;
    localparam logic [3:0] EDGE_RST = 4'h0;
    // Flag half and enable half of the two source registers
    localparam int FLAG_LSB = 4;
    // Control register bit positions
    localparam int ICTL_GIE = 0;
    localparam int ICTL_EA_EN = 1;
    localparam int ICTL_BUS_EN = 3;
    localparam int ICTL_MF4_EN = 4;
    localparam int ICTL_MF5_EN = 5;
    localparam int ICTL_EA_F = 6;
    localparam int ICTL_BUS_F = 8;
    localparam int ICTL_MF4_F = 9;
    localparam int ICTL_MF5_F = 10;
    // Edge select codes, two bits per pin
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Source indices for priority and vectors
    localparam logic [2:0] SRC_EA = 3'h0;
    localparam logic [2:0] SRC_EB = 3'h1;
    localparam logic [2:0] SRC_BUS = 3'h2;
    localparam logic [2:0] SRC_MF4 = 3'h3;
    localparam logic [2:0] SRC_MF5 = 3'h4;
    localparam int NUM_SRC = 5;

    typedef enum logic [0:0] {ST_RUN = 1'b0, ST_ENTER = 1'b1} fsm_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic [3:0] tmr;
        logic [3:0] misc;
        logic [3:0] bus;
    } src_evt_t;

    typedef struct packed {
        fsm_t fsm;
        logic [7:0] tpair;
        logic [7:0] misc;
        logic [10:0] ictl;
        logic [3:0] edge_sel;
        logic [1:0] pin_q;
        apb_rsp_t rsp;
        logic call;
        logic pop;
        logic wake;
        logic [1:0] pull;
        logic [2:0] last_src;
        logic [11:0] vec;
    } state_t;
endpackage
`default_nettype wire

// file: mcu_interrupt_arbiter.sv
// Interrupt arbiter: source flags, enables, priority, entry and return
//
// Overview of operation
// - timer pair flags in bits 7 to 4
// - timer pair enables in bits 3 to 0
// - misc flags eeprom, adc, serial, lowvolt high
// - misc enables in bits 3 to 0
// - flags set on events regardless of enable, except pin flags, which need the pin enable, and group flags, which need a member enable
// - disabled source never causes vector jump
// - global enable low blocks every jump
// - entry pushes PC and loads vector address
// - return instruction pops the saved PC
// - entry clears global enable, no nesting
// - blocked requests still latch their flags
// - software re-enable inside handler allows nesting
// - no entry while stack is full
// - fixed priority picks one of several
// - newly set flag wakes sleep or idle
// - pin edge of chosen type sets flag
// - pin armed only when fully configured
// - pin entry clears its flag and global
// - edge select rise, fall, both, off
// - pin pull-high selection kept in use
// - any bus event raises bus flag
// - bus entry needs enables, clears flag
// - group flag set by any enabled member event
// - group entry clears group flag and global, not member flags
`default_nettype none
module mcu_interrupt_arbiter
    import irq_arb_pkg::*;
#(
    // Slot 0 holds the highest priority source index
    parameter logic [14:0] PRIO_ORDER = {SRC_MF5, SRC_MF4, SRC_BUS, SRC_EB, SRC_EA},
    parameter logic [11:0] VEC_BASE = 12'h004,
    parameter logic [11:0] VEC_STEP = 12'h004
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire apb_req_t apb_in,
    output apb_rsp_t apb_out,
    input wire src_evt_t src_evt_in,
    input wire logic [1:0] ext_pins_in,
    input wire logic [1:0] pin_fn_irq_in,
    input wire logic [1:0] pin_dir_input_in,
    input wire logic [1:0] pull_sel_in,
    input wire logic stack_full_in,
    input wire logic return_from_irq_in,
    output logic irq_call_out,
    output logic [11:0] vector_addr_out,
    output logic pop_pc_out,
    output logic wake_out,
    output logic [1:0] pull_high_out
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] pick_src(input logic [NUM_SRC-1:0] c);
        logic [2:0] r;
        logic found;
        r = PRIO_ORDER[2:0];
        found = 1'b0;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (!found && c[PRIO_ORDER[k*3 +: 3]]) begin
                r = PRIO_ORDER[k*3 +: 3];
                found = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic [11:0] vec_of(input logic [2:0] idx);
        logic [23:0] p;
        p = {21'h000000, idx} * {12'h000, VEC_STEP};
        return VEC_BASE + p[11:0];
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == OFS_TPAIR) || (a == OFS_MISC) || (a == OFS_ICTL)
            || (a == OFS_EDGE) || (a == OFS_STAT);
    endfunction

    // ****************************************
    // State
    // ****************************************
    state_t s;
    state_t next_s;
    logic [NUM_SRC-1:0] cand;
    logic take;
    logic [2:0] sel;

    always_comb begin
        cand[SRC_EA] = s.ictl[ICTL_EA_F] & s.ictl[ICTL_EA_EN];
        cand[SRC_EB] = s.ictl[ICTL_EA_F + 1] & s.ictl[ICTL_EA_EN + 1];
        cand[SRC_BUS] = s.ictl[ICTL_BUS_F] & s.ictl[ICTL_BUS_EN];
        cand[SRC_MF4] = s.ictl[ICTL_MF4_F] & s.ictl[ICTL_MF4_EN];
        cand[SRC_MF5] = s.ictl[ICTL_MF5_F] & s.ictl[ICTL_MF5_EN];
        sel = pick_src(cand);
        // Global enable, a source that is enabled, a free stack slot
        take = (s.fsm == ST_RUN) && s.ictl[ICTL_GIE] && (|cand)
            && !stack_full_in;
    end

    always_comb begin
        logic rise;
        logic fall;
        logic hit;
        logic armed;
        logic [31:0] rd;
        logic [7:0] tset;
        logic [7:0] mset;
        logic [20:0] old_flags;
        logic [20:0] new_flags;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        armed = 1'b0;
        rd = 32'h0000_0000;
        tset = 8'h00;
        mset = 8'h00;
        old_flags = {s.tpair[7:4], s.misc[7:4], s.ictl[10:6], 8'h00};
        next_s = s;
        next_s.call = 1'b0;
        next_s.pop = return_from_irq_in;
        next_s.pull = pull_sel_in;
        next_s.pin_q = ext_pins_in;

        // ****************************************
        // Register bus, one wait state
        // ****************************************
        if (apb_in.psel && apb_in.penable && !s.rsp.pready) begin
            if (apb_in.paddr == OFS_TPAIR) begin
                rd = {24'h000000, s.tpair};
            end else if (apb_in.paddr == OFS_MISC) begin
                rd = {24'h000000, s.misc};
            end else if (apb_in.paddr == OFS_ICTL) begin
                rd = {21'h000000, s.ictl};
            end else if (apb_in.paddr == OFS_EDGE) begin
                rd = {28'h0000000, s.edge_sel};
            end else if (apb_in.paddr == OFS_STAT) begin
                rd = {27'h0000000, s.last_src, s.fsm, stack_full_in};
            end
            next_s.rsp.pready = 1'b1;
            next_s.rsp.prdata = rd;
            next_s.rsp.pslverr = !is_mapped(apb_in.paddr);
        end else begin
            next_s.rsp.pready = 1'b0;
            next_s.rsp.pslverr = 1'b0;
        end
        // Writes land at the edge that completes the access
        if (apb_in.psel && apb_in.penable && s.rsp.pready && apb_in.pwrite) begin
            if (apb_in.paddr == OFS_TPAIR) begin
                next_s.tpair = apb_in.pwdata[7:0];
            end else if (apb_in.paddr == OFS_MISC) begin
                next_s.misc = apb_in.pwdata[7:0];
            end else if (apb_in.paddr == OFS_ICTL) begin
                next_s.ictl = apb_in.pwdata[10:0];
            end else if (apb_in.paddr == OFS_EDGE) begin
                next_s.edge_sel = apb_in.pwdata[3:0];
            end
        end

        // ****************************************
        // Entry and return
        // ****************************************
        if (s.fsm == ST_ENTER) begin
            next_s.fsm = ST_RUN;
        end
        if (take) begin
            next_s.fsm = ST_ENTER;
            next_s.call = 1'b1;
            next_s.vec = vec_of(sel);
            next_s.last_src = sel;
            next_s.ictl[ICTL_GIE] = 1'b0;
            case (sel)
                SRC_EA: begin
                    next_s.ictl[ICTL_EA_F] = 1'b0;
                end
                SRC_EB: begin
                    next_s.ictl[ICTL_EA_F + 1] = 1'b0;
                end
                SRC_BUS: begin
                    next_s.ictl[ICTL_BUS_F] = 1'b0;
                end
                SRC_MF4: begin
                    next_s.ictl[ICTL_MF4_F] = 1'b0;
                end
                default: begin
                    next_s.ictl[ICTL_MF5_F] = 1'b0;
                end
            endcase
        end

        // ****************************************
        // Hardware sets, applied last so a set beats any clear
        // ****************************************
        for (int i = 0; i < 2; i++) begin
            rise = ext_pins_in[i] && !s.pin_q[i];
            fall = !ext_pins_in[i] && s.pin_q[i];
            hit = ((s.edge_sel[i*2 +: 2] == EDGE_RISE) && rise)
                || ((s.edge_sel[i*2 +: 2] == EDGE_FALL) && fall)
                || ((s.edge_sel[i*2 +: 2] == EDGE_BOTH) && (rise || fall));
            armed = s.ictl[ICTL_EA_EN + i] && pin_fn_irq_in[i]
                && pin_dir_input_in[i] && (s.edge_sel[i*2 +: 2] != EDGE_OFF);
            if (hit && armed) begin
                next_s.ictl[ICTL_EA_F + i] = 1'b1;
            end
        end
        if (|src_evt_in.bus) begin
            next_s.ictl[ICTL_BUS_F] = 1'b1;
        end
        tset = {src_evt_in.tmr, 4'h0};
        mset = {src_evt_in.misc, 4'h0};
        next_s.tpair = next_s.tpair | tset;
        next_s.misc = next_s.misc | mset;
        // Group flags follow enabled member requests
        if (|(src_evt_in.tmr & s.tpair[3:0])) begin
            next_s.ictl[ICTL_MF4_F] = 1'b1;
        end
        if (|(src_evt_in.misc & s.misc[3:0])) begin
            next_s.ictl[ICTL_MF5_F] = 1'b1;
        end

        // A flag already set before sleep does not wake again
        new_flags = {next_s.tpair[7:4], next_s.misc[7:4], next_s.ictl[10:6], 8'h00};
        next_s.wake = |(new_flags & ~old_flags);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{fsm: ST_RUN, tpair: TPAIR_RST, misc: MISC_RST, ictl: ICTL_RST,
                   edge_sel: EDGE_RST, pin_q: 2'h0, rsp: '0, call: 1'b0, pop: 1'b0,
                   wake: 1'b0, pull: 2'h0, last_src: 3'h0, vec: 12'h000};
        end else begin
            s <= next_s;
        end
    end

    assign apb_out = s.rsp;
    assign irq_call_out = s.call;
    assign vector_addr_out = s.vec;
    assign pop_pc_out = s.pop;
    assign wake_out = s.wake;
    assign pull_high_out = s.pull;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_call_needs_gie: assert property (irq_call_out |-> $past(s.ictl[ICTL_GIE]))
        else $error("Entry taken with global enable low");
    a_call_stack_free: assert property (irq_call_out |-> !$past(stack_full_in))
        else $error("Entry taken with stack full");
    a_call_clears_gie: assert property (irq_call_out |-> !s.ictl[ICTL_GIE])
        else $error("Global enable not cleared on entry");
    a_call_src_enabled: assert property (take |-> cand[sel])
        else $error("Entry for a source not enabled");
    a_call_vector: assert property (irq_call_out |-> vector_addr_out == vec_of(s.last_src))
        else $error("Vector address does not match source");
    a_return_pop: assert property (return_from_irq_in |=> pop_pc_out)
        else $error("Return did not pop");
    a_bus_flag_set: assert property (|src_evt_in.bus |=> s.ictl[ICTL_BUS_F])
        else $error("Bus event lost");
    a_tmr_flag_set: assert property (src_evt_in.tmr[0] |=> s.tpair[FLAG_LSB])
        else $error("Timer match flag not set");
    a_wake_on_flag: assert property ($rose(s.ictl[ICTL_EA_F]) |-> wake_out)
        else $error("No wake on new pin flag");
    a_single_entry: assert property (irq_call_out |=> !irq_call_out ##1 1'b1)
        else $error("Back to back entries");

    // ****************************************
    // Register bus checks
    // ****************************************
    // One wait state, then a single-cycle answer
    a_pready_answer: assert property (apb_in.psel && apb_in.penable && !apb_out.pready
        |=> apb_out.pready)
        else $error("Access not answered after one wait state");

    a_pready_pulse: assert property (apb_out.pready |=> !apb_out.pready)
        else $error("Ready held longer than one cycle");

    a_unmapped_err: assert property (apb_in.psel && apb_in.penable && !apb_out.pready
        && !is_mapped(apb_in.paddr) |=> apb_out.pslverr)
        else $error("Unmapped access not refused");

    // ****************************************
    // Flag checks
    // ****************************************
    a_misc_flag_set: assert property (src_evt_in.misc[3] |=> s.misc[7])
        else $error("Misc source flag not set");

    a_grp4_flag_set: assert property (|(src_evt_in.tmr & s.tpair[3:0])
        |=> s.ictl[ICTL_MF4_F])
        else $error("Timer group flag not set");

    a_grp5_flag_set: assert property (|(src_evt_in.misc & s.misc[3:0])
        |=> s.ictl[ICTL_MF5_F])
        else $error("Misc group flag not set");

    // Member flags are left for software to clear
    a_member_kept: assert property (irq_call_out && !$past(apb_in.psel)
        |-> (s.misc[7:4] & $past(s.misc[7:4])) == $past(s.misc[7:4]))
        else $error("Member flag cleared by entry");

    a_bus_entry_clear: assert property (irq_call_out && s.last_src == SRC_BUS
        && !$past(|src_evt_in.bus) |-> !s.ictl[ICTL_BUS_F])
        else $error("Bus flag not cleared on entry");

    a_grp5_entry_clear: assert property (irq_call_out && s.last_src == SRC_MF5
        && !$past(|(src_evt_in.misc & s.misc[3:0])) |-> !s.ictl[ICTL_MF5_F])
        else $error("Group flag not cleared on entry");

    // ****************************************
    // Entry checks
    // ****************************************
    a_no_call_gie_low: assert property (!s.ictl[ICTL_GIE] |=> !irq_call_out)
        else $error("Entry while global enable low");

    a_no_call_full: assert property (stack_full_in |=> !irq_call_out)
        else $error("Entry while stack full");

    a_prio_first: assert property (take && cand[PRIO_ORDER[2:0]]
        |-> sel == PRIO_ORDER[2:0])
        else $error("Highest priority source not chosen");

    a_pop_needs_return: assert property (pop_pc_out |-> $past(return_from_irq_in))
        else $error("Pop without return");

    // The entry state lasts one cycle so entries are spaced
    a_enter_one_cycle: assert property (s.fsm == ST_ENTER |=> s.fsm == ST_RUN)
        else $error("Entry state stuck");

    a_vector_holds: assert property (!take |=> $stable(vector_addr_out))
        else $error("Vector changed without entry");

    // ****************************************
    // Pin checks
    // ****************************************
    a_pin_rise_set: assert property (s.edge_sel[1:0] == EDGE_RISE && s.ictl[ICTL_EA_EN]
        && pin_fn_irq_in[0] && pin_dir_input_in[0] && ext_pins_in[0] && !s.pin_q[0]
        |=> s.ictl[ICTL_EA_F])
        else $error("Rising pin edge lost");

    a_pin_off_quiet: assert property (s.edge_sel[1:0] == EDGE_OFF && !s.ictl[ICTL_EA_F]
        && !apb_in.psel |=> !s.ictl[ICTL_EA_F])
        else $error("Pin flag set with edge select off");

    a_pin_unarmed: assert property (!pin_fn_irq_in[0] && !s.ictl[ICTL_EA_F]
        && !apb_in.psel |=> !s.ictl[ICTL_EA_F])
        else $error("Pin flag set while not selected");

    a_pull_follow: assert property (1'b1 |=> pull_high_out == $past(pull_sel_in))
        else $error("Pull-high selection not kept");

    // ****************************************
    // Coverage
    // ****************************************
    c_stack_release: cover property (stack_full_in ##1 !stack_full_in ##[1:4] irq_call_out);

    c_nested_entry: cover property (irq_call_out ##[1:40] irq_call_out);
    c_group_entry: cover property (irq_call_out && s.last_src == SRC_MF5);
    c_stack_block: cover property (stack_full_in && s.ictl[ICTL_GIE] && (|cand));
    c_pin_entry: cover property (irq_call_out && s.last_src == SRC_EA);

endmodule
`default_nettype wire

// file: irq_core_model.sv
// Behavioural processor core that stacks vector calls and issues returns
`default_nettype none
module irq_core_model #(
    parameter int DEPTH = 2
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic call_in,
    input wire logic pop_in,
    input wire logic ret_cmd_in,
    output logic return_from_irq_out,
    output logic stack_full_out,
    output int depth_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Call stack
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            depth_out <= 0;
            return_from_irq_out <= 1'b0;
        end else begin
            depth_out <= depth_out + int'(call_in) - int'(pop_in);
            // A return without a stacked call would underflow the stack
            return_from_irq_out <= ret_cmd_in && depth_out > 0;
        end
    end
    // Kept small so that nesting fills the stack quickly
    assign stack_full_out = (depth_out == DEPTH);
endmodule
`default_nettype wire

// file: mcu_interrupt_arbiter_tb.sv
// Self-checking bench for the interrupt arbiter
`default_nettype none
module mcu_interrupt_arbiter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_arb_pkg::*;
    localparam logic [11:0] VB = 12'h004;
    localparam logic [11:0] VS = 12'h004;
    localparam logic [7:0] OFS_NONE = 8'h14;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    src_evt_t evt = '0;
    logic [1:0] pins = 2'h0;
    logic [1:0] fn = 2'h0;
    logic [1:0] dir = 2'h0;
    logic [1:0] pull = 2'h0;
    logic ret_cmd = 1'b0;
    logic full, ret_irq, call, pop, wake, err;
    logic [11:0] vec;
    logic [1:0] pull_hi;
    logic [31:0] rd;
    logic [1:0] codes [4] = '{EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH};
    int depth;
    int n_mismatch = 0;
    int comparisons = 0;
    // ****************************************
    // Clock, design and core model
    // ****************************************
    always #12.5 clk_in = ~clk_in;
    mcu_interrupt_arbiter #(.VEC_BASE(VB), .VEC_STEP(VS)) u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(req), .apb_out(rsp),
        .src_evt_in(evt), .ext_pins_in(pins), .pin_fn_irq_in(fn), .pin_dir_input_in(dir),
        .pull_sel_in(pull), .stack_full_in(full), .return_from_irq_in(ret_irq),
        .irq_call_out(call), .vector_addr_out(vec), .pop_pc_out(pop), .wake_out(wake),
        .pull_high_out(pull_hi));
    irq_core_model #(.DEPTH(2)) u_core (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .call_in(call), .pop_in(pop),
        .ret_cmd_in(ret_cmd), .return_from_irq_out(ret_irq), .stack_full_out(full),
        .depth_out(depth));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic conclude();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        n_mismatch++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fail(m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_in);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (rsp.pready === 1'b1) break;
        end
        if (i == 20) begin
            fail("bus timeout");
            conclude();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask
    task automatic pulse(input src_evt_t e);
        @(posedge clk_in);
        evt <= e;
        @(posedge clk_in);
        evt <= '0;
    endtask
    task automatic pin(input logic [1:0] v);
        @(posedge clk_in);
        pins <= v;
        repeat (3) @(posedge clk_in);
    endtask
    // Sel 0 vector call, 1 pc pop, 2 wake
    task automatic wait_for(input int sel, input string m);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            if ((sel == 0 && call === 1'b1) || (sel == 1 && pop === 1'b1)
                || (sel == 2 && wake === 1'b1)) begin
                comparisons++;
                return;
            end
        end
        fail(m);
    endtask
    task automatic no_call(input int n);
        repeat (n) begin
            @(posedge clk_in);
            chk({31'h0, call}, 32'h0, "unexpected vector call");
        end
    endtask
    task automatic call_chk(input logic [2:0] src);
        wait_for(0, "no vector call");
        chk({20'h0, vec}, {20'h0, VB + 12'(src) * VS}, "vector address");
    endtask
    task automatic ret();
        @(posedge clk_in);
        ret_cmd <= 1'b1;
        @(posedge clk_in);
        ret_cmd <= 1'b0;
        wait_for(1, "no pc pop");
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd_chk(OFS_TPAIR, 32'(TPAIR_RST), "timer pair reset");
        rd_chk(OFS_MISC, 32'(MISC_RST), "misc reset");
        rd_chk(OFS_ICTL, 32'(ICTL_RST), "control reset");
        rd_chk(OFS_EDGE, 32'(EDGE_RST), "edge reset");
        apb(1'b1, OFS_TPAIR, 32'h0000_00A5);
        rd_chk(OFS_TPAIR, 32'h0000_00A5, "timer pair readback");
        apb(1'b1, OFS_MISC, 32'h0000_005A);
        rd_chk(OFS_MISC, 32'h0000_005A, "misc readback");
        apb(1'b1, OFS_TPAIR, 32'h0);
        apb(1'b1, OFS_MISC, 32'h0);
        apb(1'b0, OFS_NONE, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped not refused");
    endtask
    task automatic t_masked();
        pulse('{tmr: 4'hF, misc: 4'h0, bus: 4'h0});
        wait_for(2, "no wake");
        rd_chk(OFS_TPAIR, 32'h0000_00F0, "timer flags");
        apb(1'b1, OFS_ICTL, 32'h0000_0011);
        no_call(6);
        apb(1'b1, OFS_TPAIR, 32'h0);
        apb(1'b1, OFS_ICTL, 32'h0);
    endtask
    task automatic t_group();
        apb(1'b1, OFS_MISC, 32'h0000_000F);
        apb(1'b1, OFS_ICTL, 32'h0000_0020);
        pulse('{tmr: 4'h0, misc: 4'h4, bus: 4'h0});
        rd_chk(OFS_MISC, 32'h0000_004F, "misc flags");
        rd_chk(OFS_ICTL, 32'h0000_0420, "group flag");
        no_call(4);
        apb(1'b1, OFS_ICTL, 32'h0000_0421);
        call_chk(SRC_MF5);
        rd_chk(OFS_ICTL, 32'h0000_0020, "entry clears");
        rd_chk(OFS_MISC, 32'h0000_004F, "member flag kept");
        ret();
        apb(1'b1, OFS_MISC, 32'h0);
        apb(1'b1, OFS_ICTL, 32'h0);
    endtask
    task automatic t_prio();
        apb(1'b1, OFS_TPAIR, 32'h0000_0008);
        apb(1'b1, OFS_ICTL, 32'h0000_0018);
        pulse('{tmr: 4'h8, misc: 4'h0, bus: 4'h1});
        rd_chk(OFS_ICTL, 32'h0000_0318, "two pending");
        apb(1'b1, OFS_ICTL, 32'h0000_0319);
        call_chk(SRC_BUS);
        rd_chk(OFS_ICTL, 32'h0000_0218, "bus entry clears");
        apb(1'b1, OFS_ICTL, 32'h0000_0219);
        call_chk(SRC_MF4);
        pulse('{tmr: 4'h0, misc: 4'h0, bus: 4'h2});
        apb(1'b1, OFS_ICTL, 32'h0000_0119);
        no_call(6);
        rd_chk(OFS_ICTL, 32'h0000_0119, "held while full");
        ret();
        call_chk(SRC_BUS);
        ret();
        ret();
        apb(1'b1, OFS_TPAIR, 32'h0);
        apb(1'b1, OFS_ICTL, 32'h0);
    endtask
    task automatic t_bus();
        for (int k = 0; k < 4; k++) begin
            pulse('{tmr: 4'h0, misc: 4'h0, bus: 4'(1 << k)});
            rd_chk(OFS_ICTL, 32'h0000_0100, "bus event flag");
            apb(1'b1, OFS_ICTL, 32'h0);
        end
    endtask
    task automatic t_pins();
        @(posedge clk_in);
        fn <= 2'h3;
        dir <= 2'h3;
        pull <= 2'h2;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_EDGE, {30'h0, codes[i]});
            apb(1'b1, OFS_ICTL, 32'h0000_0002);
            pin(2'h1);
            rd_chk(OFS_ICTL, {25'h0, codes[i][0], 6'h02}, "rising edge");
            apb(1'b1, OFS_ICTL, 32'h0000_0002);
            pin(2'h0);
            rd_chk(OFS_ICTL, {25'h0, codes[i][1], 6'h02}, "falling edge");
        end
        apb(1'b1, OFS_ICTL, 32'h0000_0002);
        fn <= 2'h0;
        pin(2'h1);
        rd_chk(OFS_ICTL, 32'h0000_0002, "unselected pin");
        dir <= 2'h2;
        pin(2'h0);
        rd_chk(OFS_ICTL, 32'h0000_0002, "output pin");
        dir <= 2'h3;
        pin(2'h1);
        fn <= 2'h3;
        pin(2'h0);
        rd_chk(OFS_ICTL, 32'h0000_0042, "armed pin");
        chk({30'h0, pull_hi}, 32'h2, "pull-high lost");
        apb(1'b1, OFS_ICTL, 32'h0000_0043);
        call_chk(SRC_EA);
        rd_chk(OFS_ICTL, 32'h0000_0002, "pin entry clears");
        ret();
        apb(1'b1, OFS_EDGE, 32'h0000_000C);
        apb(1'b1, OFS_ICTL, 32'h0000_0004);
        pin(2'h2);
        rd_chk(OFS_ICTL, 32'h0000_0084, "second pin");
        apb(1'b1, OFS_ICTL, 32'h0000_0085);
        call_chk(SRC_EB);
        rd_chk(OFS_ICTL, 32'h0000_0004, "second pin entry clears");
        rd_chk(OFS_STAT, 32'h0000_0004, "status source");
        ret();
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_masked();
        t_group();
        t_prio();
        t_bus();
        t_pins();
        conclude();
    end
endmodule
`default_nettype wire
